// File: mftal_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none
module mftal_delay_timer (
  input  wire logic         core_clk,  // system clock
  input  wire logic         sys_rst,   // synchronous reset, high
  input  wire logic         tick,      // one-cycle tenths enable
  mftal_dly_if.timer        dly        // condition, delay and result
);

  logic [mftal_pkg::DLY_W-1:0] count_r;
  logic [mftal_pkg::DLY_W-1:0] prev_delay_r;
  logic                        done_r;
  logic                        restart;
  logic                        expired;

  // a lapse of the condition or a new setting starts timing afresh
  assign restart = !dly.cond || (dly.delay != prev_delay_r);
  assign expired = count_r >= dly.delay;
  assign dly.done = done_r;

  // count tenths while the condition holds without a break
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_r      <= '0;
      prev_delay_r <= '0;
      done_r       <= 1'b0;
    end else begin
      prev_delay_r <= dly.delay;
      if (restart) begin
        count_r <= '0;
        done_r  <= 1'b0;
      end else if (expired) begin
        done_r  <= 1'b1;
      end else if (tick) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

endmodule // mftal_delay_timer
`default_nettype wire

// File: mftal_dly_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mftal_dly_if;
  logic                           cond;   // condition to be timed
  logic [mftal_pkg::DLY_W-1:0]    delay;  // delay setting in tenths
  logic                           done;   // condition held for the full delay

  modport timer (input cond, input delay, output done);
  modport ctrl  (output cond, output delay, input done);
endinterface
`default_nettype wire

// File: mftal_pkg.sv
`default_nettype none
package mftal_pkg;

  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 8;              // core_clk period
  localparam int unsigned TENTH_NS      = 100_000_000;    // one tenth of a second in ns
  localparam int unsigned TICK_CYCLES   = TENTH_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 24;             // width of the tenths divider

  // data widths
  localparam int unsigned CUR_W  = 16;                    // current in 0.1 A units
  localparam int unsigned PCT_W  = 7;                     // percent settings, 0 means off
  localparam int unsigned DLY_W  = 12;                    // delays in tenths of a second
  localparam int unsigned VOLT_W = 9;                     // control voltage in volts
  localparam int unsigned CMP_W  = 24;                    // scaled comparison width

  // scaling constants
  localparam logic [PCT_W-1:0] PCT_SCALE   = 7'h64;       // 100 percent
  localparam logic [PCT_W-1:0] STALL_SCALE = 7'h0A;       // stall level in tenths of x full load
  localparam logic [PCT_W-1:0] SENS_SCALE  = 7'h0A;       // whole amps to 0.1 A units
  localparam logic [PCT_W-1:0] LEVEL_OFF   = 7'h00;       // level code meaning off

  // undervoltage figures
  localparam logic [VOLT_W-1:0] DROP_120_V    = 9'h055;   // 85 V
  localparam logic [VOLT_W-1:0] DROP_240_V    = 9'h0AA;   // 170 V
  localparam logic [DLY_W-1:0]  QUICK_TENTHS  = 12'h002;  // 0.2 s immediate restart limit
  localparam logic [DLY_W-1:0]  WINDOW_TENTHS = 12'h02D;  // 4.5 s window restart limit
  localparam logic [DLY_W-1:0]  DLY_MAX       = 12'hFFF;  // saturation of the outage count

  // delay timer channels
  localparam int unsigned N_TMR     = 5;
  localparam int unsigned T_GF_TRIP = 0;
  localparam int unsigned T_GF_ALM  = 1;
  localparam int unsigned T_STALL   = 2;
  localparam int unsigned T_UC_TRIP = 3;
  localparam int unsigned T_UC_ALM  = 4;

  // undervoltage supervisor states
  typedef enum logic [3:0] {
    UV_NORMAL = 4'b0001,
    UV_DROP   = 4'b0010,
    UV_WAIT   = 4'b0100,
    UV_LOCK   = 4'b1000
  } mftal_uv_e;

  // motor mode states
  typedef enum logic [2:0] {
    MOT_STOP  = 3'b001,
    MOT_START = 3'b010,
    MOT_RUN   = 3'b100
  } mftal_mot_e;

endpackage
`default_nettype wire

// File: mftal_starter_model.sv
`timescale 1ns/100ps
`default_nettype none
module mftal_starter_model (
  input  wire logic        core_clk,      // system clock
  input  wire logic        contactor_a_r, // contactor a drive
  input  wire logic        contactor_b_r, // contactor b drive
  input  wire logic [15:0] load_level,    // current drawn when closed
  output var  logic [15:0] phase_current  // sensed running current
);
  // current flows only through a closed contactor, one cycle behind
  always @(posedge core_clk) begin
    phase_current <= (contactor_a_r | contactor_b_r) ? load_level : 16'h0000;
  end
endmodule // mftal_starter_model
`default_nettype wire

// File: mftal_top.sv
`timescale 1ns/100ps
`default_nettype none
module mftal_top #(
  parameter int unsigned TICK_CYCLES = mftal_pkg::TICK_CYCLES  // cycles per tenth of a second
) (
  input  wire logic                          core_clk,        // 125 MHz system clock
  input  wire logic                          sys_rst,         // synchronous reset, high
  input  wire logic [mftal_pkg::CUR_W-1:0]   phase_current,   // running current, 0.1 A units
  input  wire logic [mftal_pkg::CUR_W-1:0]   ground_current,  // ground leakage, 0.1 A units
  input  wire logic [mftal_pkg::VOLT_W-1:0]  control_volts,   // control voltage in volts
  input  wire logic [mftal_pkg::CUR_W-1:0]   full_load_current_setting, // 0.1 A units
  input  wire logic                          gf_sensitive,    // high: sensitive ground sensor
  input  wire logic [mftal_pkg::PCT_W-1:0]   gf_trip_level,   // percent or amps, 0 off
  input  wire logic [mftal_pkg::DLY_W-1:0]   gf_trip_delay,   // tenths, 0-20
  input  wire logic [mftal_pkg::PCT_W-1:0]   gf_alarm_level,  // percent or amps, 0 off
  input  wire logic [mftal_pkg::DLY_W-1:0]   gf_alarm_delay,  // tenths, 10-600
  input  wire logic [mftal_pkg::PCT_W-1:0]   stall_level,     // tenths of x full load, 0 off
  input  wire logic [mftal_pkg::DLY_W-1:0]   stall_delay,     // tenths, 5-50
  input  wire logic [mftal_pkg::PCT_W-1:0]   uc_trip_level,   // percent, 0 off
  input  wire logic [mftal_pkg::DLY_W-1:0]   uc_trip_delay,   // tenths, 10-600
  input  wire logic [mftal_pkg::PCT_W-1:0]   uc_alarm_level,  // percent, 0 off
  input  wire logic [mftal_pkg::DLY_W-1:0]   uc_alarm_delay,  // tenths, 10-600
  input  wire logic [mftal_pkg::PCT_W-1:0]   load_incr_level, // percent, 0 off
  input  wire logic                          aux_is_alarm,    // aux relay assigned to alarms
  input  wire logic                          volt_sel_240,    // high: 240 V control supply
  input  wire logic                          uv_restart_en,   // undervoltage restart enabled
  input  wire logic                          window_limited_restart, // high: 4.5 s window
  input  wire logic [mftal_pkg::DLY_W-1:0]   restart_delay,   // tenths, 2-3000
  input  wire logic                          run_req_a,       // starter asks for contactor a
  input  wire logic                          run_req_b,       // starter asks for contactor b
  input  wire logic                          trip_reset,      // one-cycle clear of latched trips
  output var  logic                          contactor_a_r,   // contactor a drive
  output var  logic                          contactor_b_r,   // contactor b drive
  output var  logic                          gf_trip_r,       // latched ground fault trip
  output var  logic                          stall_trip_r,    // latched stalled rotor trip
  output var  logic                          uc_trip_r,       // latched undercurrent trip
  output var  logic                          gf_alarm_r,      // ground fault alarm
  output var  logic                          uc_alarm_r,      // undercurrent alarm
  output var  logic                          aux_relay_r,     // load increase relay
  output var  logic                          motor_starting_r, // motor in start mode
  output var  logic                          uv_dropped_r     // contactors held off by voltage
);

  localparam logic [mftal_pkg::TICK_W-1:0] TICK_LAST = mftal_pkg::TICK_W'(TICK_CYCLES - 1);

  logic [mftal_pkg::TICK_W-1:0] tick_cnt_r;
  logic                         tick_r;
  mftal_pkg::mftal_mot_e        mot_r;
  mftal_pkg::mftal_mot_e        mot_nxt;
  mftal_pkg::mftal_uv_e         uv_r;
  mftal_pkg::mftal_uv_e         uv_nxt;
  logic [mftal_pkg::DLY_W-1:0]  out_cnt_r;
  logic [mftal_pkg::DLY_W-1:0]  out_cnt_nxt;
  logic [mftal_pkg::N_TMR-1:0]  tmr_cond;
  logic [mftal_pkg::DLY_W-1:0]  tmr_delay [mftal_pkg::N_TMR];
  logic [mftal_pkg::N_TMR-1:0]  tmr_done;

  // tenths of a second timebase
  logic tick_hit;
  assign tick_hit = (tick_cnt_r == TICK_LAST);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= tick_hit;
      tick_cnt_r <= tick_hit ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // scaled quantities: current x100 against full load x percent
  logic [mftal_pkg::CMP_W-1:0] cur_x100;
  logic [mftal_pkg::CMP_W-1:0] cur_x10;
  logic [mftal_pkg::CMP_W-1:0] gnd_x100;
  logic [mftal_pkg::CMP_W-1:0] gnd_x1;
  logic [mftal_pkg::CMP_W-1:0] flc_x1;
  assign gnd_x1   = mftal_pkg::CMP_W'(ground_current);
  assign flc_x1   = mftal_pkg::CMP_W'(full_load_current_setting);
  assign cur_x100 = mftal_pkg::CMP_W'(phase_current) * mftal_pkg::CMP_W'(mftal_pkg::PCT_SCALE);
  assign cur_x10  = mftal_pkg::CMP_W'(phase_current) * mftal_pkg::CMP_W'(mftal_pkg::STALL_SCALE);
  assign gnd_x100 = gnd_x1 * mftal_pkg::CMP_W'(mftal_pkg::PCT_SCALE);

  // full load scaled by each level; sensitive ground levels in 0.1 A units
  logic [mftal_pkg::CMP_W-1:0] gf_trip_flc;
  logic [mftal_pkg::CMP_W-1:0] gf_alarm_flc;
  logic [mftal_pkg::CMP_W-1:0] stall_flc;
  logic [mftal_pkg::CMP_W-1:0] uc_trip_flc;
  logic [mftal_pkg::CMP_W-1:0] uc_alarm_flc;
  logic [mftal_pkg::CMP_W-1:0] load_incr_flc;
  logic [mftal_pkg::CMP_W-1:0] gf_trip_amps;
  logic [mftal_pkg::CMP_W-1:0] gf_alarm_amps;
  assign gf_trip_flc   = flc_x1 * mftal_pkg::CMP_W'(gf_trip_level);
  assign gf_alarm_flc  = flc_x1 * mftal_pkg::CMP_W'(gf_alarm_level);
  assign stall_flc     = flc_x1 * mftal_pkg::CMP_W'(stall_level);
  assign uc_trip_flc   = flc_x1 * mftal_pkg::CMP_W'(uc_trip_level);
  assign uc_alarm_flc  = flc_x1 * mftal_pkg::CMP_W'(uc_alarm_level);
  assign load_incr_flc = flc_x1 * mftal_pkg::CMP_W'(load_incr_level);
  assign gf_trip_amps  = mftal_pkg::CMP_W'(gf_trip_level) * mftal_pkg::CMP_W'(mftal_pkg::SENS_SCALE);
  assign gf_alarm_amps = mftal_pkg::CMP_W'(gf_alarm_level) * mftal_pkg::CMP_W'(mftal_pkg::SENS_SCALE);

  // ground leakage against percent of full load or sensitive amps
  logic gf_trip_over;
  logic gf_alarm_over;
  assign gf_trip_over  = gf_sensitive ? (gnd_x1 > gf_trip_amps) : (gnd_x100 > gf_trip_flc);
  assign gf_alarm_over = gf_sensitive ? (gnd_x1 > gf_alarm_amps) : (gnd_x100 > gf_alarm_flc);

  // detections; a zero level switches the function and its delay off
  logic is_running;
  logic gf_trip_det;
  logic gf_alarm_det;
  logic stall_det;
  logic uc_trip_det;
  logic uc_alarm_det;
  logic load_incr_det;
  assign is_running    = (mot_r == mftal_pkg::MOT_RUN);
  assign gf_trip_det   = (gf_trip_level != mftal_pkg::LEVEL_OFF) && gf_trip_over;
  assign gf_alarm_det  = (gf_alarm_level != mftal_pkg::LEVEL_OFF) && gf_alarm_over;
  assign stall_det     = (stall_level != mftal_pkg::LEVEL_OFF) && is_running
                         && (cur_x10 > stall_flc);
  assign uc_trip_det   = (uc_trip_level != mftal_pkg::LEVEL_OFF) && is_running
                         && (cur_x100 < uc_trip_flc);
  assign uc_alarm_det  = (uc_alarm_level != mftal_pkg::LEVEL_OFF) && is_running
                         && (cur_x100 < uc_alarm_flc);
  assign load_incr_det = (load_incr_level != mftal_pkg::LEVEL_OFF)
                         && (cur_x100 > load_incr_flc);

  // timer channel inputs
  assign tmr_cond[mftal_pkg::T_GF_TRIP]  = gf_trip_det;
  assign tmr_cond[mftal_pkg::T_GF_ALM]   = gf_alarm_det;
  assign tmr_cond[mftal_pkg::T_STALL]    = stall_det;
  assign tmr_cond[mftal_pkg::T_UC_TRIP]  = uc_trip_det;
  assign tmr_cond[mftal_pkg::T_UC_ALM]   = uc_alarm_det;
  assign tmr_delay[mftal_pkg::T_GF_TRIP] = gf_trip_delay;
  assign tmr_delay[mftal_pkg::T_GF_ALM]  = gf_alarm_delay;
  assign tmr_delay[mftal_pkg::T_STALL]   = stall_delay;
  assign tmr_delay[mftal_pkg::T_UC_TRIP] = uc_trip_delay;
  assign tmr_delay[mftal_pkg::T_UC_ALM]  = uc_alarm_delay;

  // one delay timer per protection channel
  genvar gi;
  generate
    for (gi = 0; gi < mftal_pkg::N_TMR; gi++) begin : g_tmr
      mftal_dly_if dly ();
      assign dly.cond     = tmr_cond[gi];
      assign dly.delay    = tmr_delay[gi];
      assign tmr_done[gi] = dly.done;
      mftal_delay_timer u_tmr (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tick     (tick_r),
        .dly      (dly)
      );
    end
  endgenerate

  // motor mode from current against full load
  always_comb begin
    mot_nxt = mot_r;
    case (mot_r)
      mftal_pkg::MOT_STOP: begin
        if (phase_current > full_load_current_setting)
          mot_nxt = mftal_pkg::MOT_START;
        else if (phase_current != '0)
          mot_nxt = mftal_pkg::MOT_RUN;
      end
      mftal_pkg::MOT_START: begin
        if (phase_current == '0)
          mot_nxt = mftal_pkg::MOT_STOP;
        else if (mftal_pkg::CMP_W'(phase_current) < flc_x1)
          mot_nxt = mftal_pkg::MOT_RUN;
      end
      mftal_pkg::MOT_RUN: begin
        if (phase_current == '0)
          mot_nxt = mftal_pkg::MOT_STOP;
      end
      default: mot_nxt = mftal_pkg::MOT_STOP;
    endcase
  end

  // undervoltage supervisor
  logic [mftal_pkg::VOLT_W-1:0] drop_volts;
  logic                         volt_low;
  logic                         quick_back;
  logic                         past_window;
  logic [mftal_pkg::DLY_W-1:0]  out_cnt_inc;
  logic                         restart_due;
  assign restart_due = out_cnt_r >= restart_delay;
  assign drop_volts  = volt_sel_240 ? mftal_pkg::DROP_240_V : mftal_pkg::DROP_120_V;
  assign volt_low    = control_volts < drop_volts;
  assign quick_back  = out_cnt_r <= mftal_pkg::QUICK_TENTHS;
  assign past_window = out_cnt_r >= mftal_pkg::WINDOW_TENTHS;
  assign out_cnt_inc = (tick_r && out_cnt_r != mftal_pkg::DLY_MAX) ? out_cnt_r + 1'b1 : out_cnt_r;

  always_comb begin
    uv_nxt      = uv_r;
    out_cnt_nxt = out_cnt_inc;
    case (uv_r)
      mftal_pkg::UV_NORMAL: begin
        out_cnt_nxt = '0;
        if (volt_low)
          uv_nxt = mftal_pkg::UV_DROP;
      end
      mftal_pkg::UV_DROP: begin
        if (!uv_restart_en)
          uv_nxt = mftal_pkg::UV_LOCK;
        else if (!volt_low) begin
          if (quick_back)
            uv_nxt = mftal_pkg::UV_NORMAL;
          else if (window_limited_restart && past_window)
            uv_nxt = mftal_pkg::UV_LOCK;
          else
            uv_nxt = mftal_pkg::UV_WAIT;
        end
      end
      mftal_pkg::UV_WAIT: begin
        if (volt_low) begin
          uv_nxt      = mftal_pkg::UV_DROP;
          out_cnt_nxt = '0;
        end else if (restart_due)
          uv_nxt = mftal_pkg::UV_NORMAL;
      end
      mftal_pkg::UV_LOCK: begin
        out_cnt_nxt = '0;
        if (!volt_low && !run_req_a && !run_req_b)
          uv_nxt = mftal_pkg::UV_NORMAL;
      end
      default: uv_nxt = mftal_pkg::UV_NORMAL;
    endcase
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mot_r     <= mftal_pkg::MOT_STOP;
      uv_r      <= mftal_pkg::UV_NORMAL;
      out_cnt_r <= '0;
    end else begin
      mot_r     <= mot_nxt;
      uv_r      <= uv_nxt;
      out_cnt_r <= out_cnt_nxt;
    end
  end

  // latched trips; a new trip wins over a reset in the same cycle
  logic any_trip;
  assign any_trip = gf_trip_r || stall_trip_r || uc_trip_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gf_trip_r    <= 1'b0;
      stall_trip_r <= 1'b0;
      uc_trip_r    <= 1'b0;
    end else begin
      gf_trip_r    <= tmr_done[mftal_pkg::T_GF_TRIP] || (gf_trip_r && !trip_reset);
      stall_trip_r <= tmr_done[mftal_pkg::T_STALL]   || (stall_trip_r && !trip_reset);
      uc_trip_r    <= tmr_done[mftal_pkg::T_UC_TRIP] || (uc_trip_r && !trip_reset);
    end
  end

  // alarms, relays and contactor drive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gf_alarm_r       <= 1'b0;
      uc_alarm_r       <= 1'b0;
      aux_relay_r      <= 1'b0;
      contactor_a_r    <= 1'b0;
      contactor_b_r    <= 1'b0;
      motor_starting_r <= 1'b0;
      uv_dropped_r     <= 1'b0;
    end else begin
      gf_alarm_r       <= tmr_done[mftal_pkg::T_GF_ALM];
      uc_alarm_r       <= tmr_done[mftal_pkg::T_UC_ALM];
      aux_relay_r      <= aux_is_alarm && load_incr_det;
      contactor_a_r    <= run_req_a && !any_trip && (uv_nxt == mftal_pkg::UV_NORMAL);
      contactor_b_r    <= run_req_b && !any_trip && (uv_nxt == mftal_pkg::UV_NORMAL);
      motor_starting_r <= (mot_nxt == mftal_pkg::MOT_START);
      uv_dropped_r     <= (uv_nxt != mftal_pkg::UV_NORMAL);
    end
  end

endmodule // mftal_top
`default_nettype wire

// File: mftal_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mftal_top_properties #(
  parameter int unsigned TICK_CYCLES = 10  // cycles per tenth
) (
  input wire logic        core_clk,                  // clock
  input wire logic        sys_rst,                   // reset
  input wire logic [15:0] ground_current,            // leakage
  input wire logic [8:0]  control_volts,             // volts
  input wire logic [15:0] full_load_current_setting, // full load
  input wire logic        gf_sensitive,              // amps scale
  input wire logic [6:0]  gf_trip_level,             // trip level
  input wire logic [11:0] gf_trip_delay,             // trip delay
  input wire logic [6:0]  gf_alarm_level,            // alarm level
  input wire logic [6:0]  uc_trip_level,             // uc level
  input wire logic        aux_is_alarm,              // aux use
  input wire logic        volt_sel_240,              // supply
  input wire logic        trip_reset,                // trip clear
  input wire logic        contactor_a_r,             // drive a
  input wire logic        contactor_b_r,             // drive b
  input wire logic        gf_trip_r,                 // ground trip
  input wire logic        stall_trip_r,              // stall trip
  input wire logic        uc_trip_r,                 // uc trip
  input wire logic        gf_alarm_r,                // ground alarm
  input wire logic        aux_relay_r,               // aux relay
  input wire logic        motor_starting_r,          // start mode
  input wire logic        uv_dropped_r               // held off
);
  // ground level crossing, supply dropout and any latched trip
  wire logic gf_over = gf_sensitive ? (int'(ground_current) > 10 * int'(gf_trip_level))
    : (100 * int'(ground_current) > int'(full_load_current_setting) * int'(gf_trip_level));
  wire logic uv_low = control_volts < (volt_sel_240 ? mftal_pkg::DROP_240_V : mftal_pkg::DROP_120_V);
  wire logic trip_any = gf_trip_r | stall_trip_r | uc_trip_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ground fault with zero delay, and ground alarm switched off
  sequence s_gf_now;
    gf_trip_level != mftal_pkg::LEVEL_OFF && gf_trip_delay == 12'h000 && gf_over;
  endsequence
  sequence s_alm_off;
    (gf_alarm_level == mftal_pkg::LEVEL_OFF) [*2];
  endsequence

  a_gf_fast_trip: assert property (s_gf_now [*3] |=> gf_trip_r)
    else $error("ground trip missing after zero delay");
  a_gf_trip_hold: assert property (gf_trip_r && !trip_reset |=> gf_trip_r)
    else $error("ground trip dropped without clear");
  a_gf_alarm_off: assert property (s_alm_off |=> !gf_alarm_r)
    else $error("ground alarm while level off");
  a_uc_level_off: assert property ((uc_trip_level == mftal_pkg::LEVEL_OFF) [*2] ##0 !uc_trip_r |=> !uc_trip_r)
    else $error("undercurrent trip while level off");
  a_stall_inrush: assert property (motor_starting_r && !stall_trip_r |=> !stall_trip_r)
    else $error("stall trip during start");
  a_uv_open: assert property (uv_low |=> !contactor_a_r && !contactor_b_r && uv_dropped_r)
    else $error("contactor held under dropout");
  a_trip_blocks: assert property (trip_any ##1 trip_any |-> !contactor_a_r && !contactor_b_r)
    else $error("contactor on while tripped");
  a_aux_unassigned: assert property ((!aux_is_alarm) [*2] |=> !aux_relay_r)
    else $error("aux relay on while unassigned");
endmodule // mftal_top_properties

bind mftal_top mftal_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_mftal_top_properties (
  .core_clk, .sys_rst, .ground_current, .control_volts, .full_load_current_setting, .gf_sensitive,
  .gf_trip_level, .gf_trip_delay, .gf_alarm_level, .uc_trip_level, .aux_is_alarm, .volt_sel_240,
  .trip_reset, .contactor_a_r, .contactor_b_r, .gf_trip_r, .stall_trip_r, .uc_trip_r, .gf_alarm_r,
  .aux_relay_r, .motor_starting_r, .uv_dropped_r
);
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] ground_current = 16'h0000, full_load_current_setting = 16'h0064, load_level = 16'h0032;
  logic [8:0]  control_volts = 9'h0F0;
  logic [6:0]  gf_trip_level = 7'h00, gf_alarm_level = 7'h00, stall_level = 7'h00,
               uc_trip_level = 7'h00, uc_alarm_level = 7'h00, load_incr_level = 7'h00;
  logic [11:0] gf_trip_delay = 12'h000, gf_alarm_delay = 12'h00A, stall_delay = 12'h005,
               uc_trip_delay = 12'h00A, uc_alarm_delay = 12'h005, restart_delay = 12'h028;
  logic        gf_sensitive = 1'b0, aux_is_alarm = 1'b1, volt_sel_240 = 1'b0, uv_restart_en = 1'b0;
  logic        window_limited_restart = 1'b1, run_req_a = 1'b1, run_req_b = 1'b1, trip_reset = 1'b0;
  wire  [15:0] phase_current;
  logic        contactor_a_r, contactor_b_r, gf_trip_r, stall_trip_r, uc_trip_r;
  logic        gf_alarm_r, uc_alarm_r, aux_relay_r, motor_starting_r, uv_dropped_r;
  int          fails = 0;
  int          comparisons = 0;

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  mftal_top #(.TICK_CYCLES(10)) u_mftal_top (
    .core_clk, .sys_rst, .phase_current, .ground_current, .control_volts, .full_load_current_setting,
    .gf_sensitive, .gf_trip_level, .gf_trip_delay, .gf_alarm_level, .gf_alarm_delay, .stall_level,
    .stall_delay, .uc_trip_level, .uc_trip_delay, .uc_alarm_level, .uc_alarm_delay, .load_incr_level,
    .aux_is_alarm, .volt_sel_240, .uv_restart_en, .window_limited_restart, .restart_delay, .run_req_a,
    .run_req_b, .trip_reset, .contactor_a_r, .contactor_b_r, .gf_trip_r, .stall_trip_r, .uc_trip_r,
    .gf_alarm_r, .uc_alarm_r, .aux_relay_r, .motor_starting_r, .uv_dropped_r
  );
  mftal_starter_model u_mftal_starter_model (
    .core_clk, .contactor_a_r, .contactor_b_r, .load_level, .phase_current
  );

  // edge waits; look lets the edge updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-edge trip clear, supply level change, run request re-arm
  task automatic clr_trip;
    trip_reset <= 1'b1;
    cyc(1);
    trip_reset <= 1'b0;
  endtask
  task automatic uv(input logic [8:0] v, input int n);
    control_volts <= v;
    look(n);
  endtask
  task automatic rearm;
    run_req_a <= 1'b0;
    run_req_b <= 1'b0;
    look(3);
    run_req_a <= 1'b1;
    run_req_b <= 1'b1;
    look(3);
  endtask
  task automatic results;
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    cyc(20000);
    fails++;
    results();
  end

  // main sequence
  initial begin
    cyc(8);
    #1;
    chk({contactor_a_r, contactor_b_r, gf_trip_r, stall_trip_r, uc_trip_r, gf_alarm_r, uc_alarm_r,
         aux_relay_r, motor_starting_r, uv_dropped_r}, 16'h0000);
    sys_rst <= 1'b0;
    // dropout thresholds on both supplies, restart disabled
    for (int i = 0; i < 2; i++) begin
      volt_sel_240 <= i[0];
      uv(i[0] ? 9'h0AA : 9'h055, 3);
      chk({contactor_a_r, contactor_b_r}, 16'h0003);
      uv(i[0] ? 9'h0A9 : 9'h054, 1);
      chk({contactor_a_r, contactor_b_r, uv_dropped_r}, 16'h0001);
      uv(9'h0F0, 20);
      chk(contactor_a_r, 16'h0000);
      rearm;
      chk({contactor_a_r, uv_dropped_r}, 16'h0002);
    end
    // quick return, window restart, long loss, unlimited restart
    uv_restart_en <= 1'b1;
    uv(9'h000, 10);
    uv(9'h0F0, 3);
    chk(contactor_a_r, 16'h0001);
    uv(9'h000, 100);
    uv(9'h0F0, 200);
    chk(contactor_a_r, 16'h0000);
    look(130);
    chk(contactor_a_r, 16'h0001);
    uv(9'h000, 500);
    uv(9'h0F0, 600);
    chk(contactor_a_r, 16'h0000);
    window_limited_restart <= 1'b0;
    restart_delay <= 12'h050;
    rearm;
    uv(9'h000, 500);
    uv(9'h0F0, 200);
    chk(contactor_a_r, 16'h0000);
    look(150);
    chk(contactor_a_r, 16'h0001);
    // ground trip at the level edge, percent and amps scales
    for (int s = 0; s < 2; s++) begin
      gf_sensitive <= s[0];
      gf_trip_level <= s[0] ? 7'h05 : 7'h32;
      ground_current <= 16'h0032;
      look(20);
      chk(gf_trip_r, 16'h0000);
      ground_current <= 16'h0033;
      look(3);
      chk(gf_trip_r, 16'h0001);
      look(1);
      chk(contactor_a_r, 16'h0000);
      ground_current <= 16'h0000;
      look(3);
      clr_trip;
      look(0);
      chk(gf_trip_r, 16'h0000);
      look(3);
    end
    gf_trip_delay <= 12'h014;
    ground_current <= 16'h0033;
    look(185);
    chk(gf_trip_r, 16'h0000);
    look(40);
    chk(gf_trip_r, 16'h0001);
    ground_current <= 16'h0000;
    look(3);
    clr_trip;
    gf_trip_level <= 7'h00;
    ground_current <= 16'h03E8;
    look(300);
    chk(gf_trip_r, 16'h0000);
    // ground alarm: interrupted run, expiry, lapse, reload, off
    gf_alarm_level <= 7'h03;
    ground_current <= 16'h0028;
    look(50);
    ground_current <= 16'h0000;
    look(2);
    ground_current <= 16'h0028;
    look(85);
    chk(gf_alarm_r, 16'h0000);
    look(40);
    chk(gf_alarm_r, 16'h0001);
    ground_current <= 16'h0000;
    look(2);
    chk(gf_alarm_r, 16'h0000);
    ground_current <= 16'h0028;
    look(50);
    gf_alarm_delay <= 12'h00B;
    look(85);
    chk(gf_alarm_r, 16'h0000);
    gf_alarm_level <= 7'h00;
    look(150);
    chk(gf_alarm_r, 16'h0000);
    ground_current <= 16'h0000;
    // stall while running, then no stall during start inrush
    stall_level <= 7'h14;
    load_level <= 16'h00FA;
    look(35);
    chk(stall_trip_r, 16'h0000);
    look(45);
    chk(stall_trip_r, 16'h0001);
    look(5);
    clr_trip;
    look(5);
    chk(motor_starting_r, 16'h0001);
    look(100);
    chk(stall_trip_r, 16'h0000);
    load_level <= 16'h0032;
    look(4);
    chk(motor_starting_r, 16'h0000);
    stall_level <= 7'h00;
    // undercurrent alarm before undercurrent trip
    uc_trip_level <= 7'h1E;
    uc_alarm_level <= 7'h28;
    load_level <= 16'h0019;
    look(35);
    chk({uc_alarm_r, uc_trip_r}, 16'h0000);
    look(40);
    chk({uc_alarm_r, uc_trip_r}, 16'h0002);
    look(50);
    chk(uc_trip_r, 16'h0001);
    uc_trip_level <= 7'h00;
    uc_alarm_level <= 7'h00;
    load_level <= 16'h0046;
    look(5);
    clr_trip;
    // load increase relay, assignment and level edge
    load_incr_level <= 7'h3C;
    look(8);
    chk(aux_relay_r, 16'h0001);
    aux_is_alarm <= 1'b0;
    look(3);
    chk(aux_relay_r, 16'h0000);
    aux_is_alarm <= 1'b1;
    load_level <= 16'h003C;
    look(5);
    chk(aux_relay_r, 16'h0000);
    results();
  end
endmodule // tb
`default_nettype wire
